// *** deep_sleep_wake.sv ***
// Top: deep-sleep entry, wake-up and warm-up sequencer.
// Assumes firmware drives the enable and mode inputs and pulses the sleep request.
//
// Overview of operation
// - Deep sleep ends when the exit pin or key-wake pin shows release.
// - One enable bit turns the key-wake function on or off.
// - An enabled key-wake pin held low requests exit from deep sleep.
// - Release present at sleep request: skip sleep, start warm-up at once.
`timescale 1ns/1ps
`default_nettype none
module deep_sleep_wake
   import wake_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   input wire logic i_sleep_req,
   input wire logic i_exit_pin,
   input wire logic i_key_wake_pin,
   input wire logic i_key_wake_enable,
   input wire logic i_level_release_mode,
   output logic o_deep_sleep,
   output logic o_warmup_active,
   output logic o_entry_refused,
   output logic o_wake_done
);

   seq_state_t state_q;
   seq_state_t state_d;
   logic [WARM_CNT_W-1:0] warm_cnt_q;
   logic refused_q;
   logic done_q;
   logic warm_end;
   logic [WARM_CNT_W-1:0] warm_len_q;

   wake_if wif();

   assign wif.exit_pin = i_exit_pin;
   assign wif.key_wake_pin = i_key_wake_pin;
   assign wif.key_wake_enable = i_key_wake_enable;
   assign wif.level_mode = i_level_release_mode;

   wake_detect u_detect (
      .i_sys_clk(i_sys_clk),
      .i_rstn(i_rstn),
      .wif(wif)
   );

   assign warm_end = (warm_cnt_q == WARM_CNT_LAST);

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_RUN: begin
            if (i_sleep_req) begin
               // Entry refused while a release level stands
               state_d = wif.level_req ? ST_WARM : ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            if (wif.release_req) begin
               state_d = ST_WARM;
            end
         end
         ST_WARM: begin
            if (warm_end) begin
               state_d = ST_RUN;
            end
         end
         default: begin
            state_d = ST_RUN;
         end
      endcase
   end

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state_q <= ST_RUN;
      end else begin
         state_q <= state_d;
      end
   end

   // Warm-up counter, cleared outside warm-up
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         warm_cnt_q <= WARM_CNT_RST;
      end else if (state_q == ST_WARM && !warm_end) begin
         warm_cnt_q <= warm_cnt_q + 6'h01;
      end else begin
         warm_cnt_q <= WARM_CNT_RST;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         refused_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         refused_q <= (state_q == ST_RUN) && i_sleep_req && wif.level_req;
         done_q <= (state_q == ST_WARM) && warm_end;
      end
   end

   // Outputs straight from flops
   assign o_deep_sleep = state_q[ST_SLEEP_BIT];
   assign o_warmup_active = state_q[ST_WARM_BIT];
   assign o_entry_refused = refused_q;
   assign o_wake_done = done_q;

   // Enabled key pin held low
   function automatic logic key_release(input logic enable, input logic pin);
      return enable & ~pin;
   endfunction

   // Check-only warm-up count, kept apart from the sequencer counter
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         warm_len_q <= WARM_CNT_RST;
      end else if (o_warmup_active) begin
         warm_len_q <= warm_len_q + 6'h01;
      end else begin
         warm_len_q <= WARM_CNT_RST;
      end
   end

   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_rstn);

   chk_refused_entry: assert property (
      (state_q == ST_RUN) && i_sleep_req && (i_exit_pin || (i_key_wake_enable && !i_key_wake_pin))
      |=> o_warmup_active && o_entry_refused && !o_deep_sleep)
      else $error("sleep entered despite release condition");

   chk_clean_entry: assert property (
      (state_q == ST_RUN) && i_sleep_req && !i_exit_pin && !(i_key_wake_enable && !i_key_wake_pin)
      |=> o_deep_sleep && !o_entry_refused)
      else $error("sleep not entered on clean request");

   chk_key_wake_low: assert property (
      o_deep_sleep && i_key_wake_enable && !i_key_wake_pin |=> o_warmup_active)
      else $error("key-wake low did not release sleep");

   chk_key_disabled: assert property (
      o_deep_sleep && !i_key_wake_enable && !i_exit_pin |=> o_deep_sleep)
      else $error("disabled key-wake pin released sleep");

   chk_exit_level: assert property (
      o_deep_sleep && i_level_release_mode && i_exit_pin |=> o_warmup_active)
      else $error("exit pin high did not release in level mode");

   chk_exit_edge_only: assert property (
      o_deep_sleep && !i_level_release_mode && i_exit_pin && $past(i_exit_pin)
      && !(i_key_wake_enable && !i_key_wake_pin) |=> o_deep_sleep)
      else $error("steady exit level released in edge mode");

   chk_wake_cause: assert property (
      o_deep_sleep ##1 o_warmup_active |-> $past(wif.release_req))
      else $error("sleep left without a release source");

   chk_warmup_length: assert property (
      $rose(o_warmup_active) |-> o_warmup_active [*8] ##33 (o_wake_done && !o_warmup_active))
      else $error("warm-up length wrong");

   chk_warmup_count: assert property (
      $fell(o_warmup_active) |-> (warm_len_q == WARM_CNT_LAST + 6'h01) && o_wake_done)
      else $error("warm-up did not last the full count");

   chk_warmup_bound: assert property (
      o_warmup_active |-> warm_len_q <= WARM_CNT_LAST)
      else $error("warm-up ran past its count");

   chk_refused_pulse: assert property (
      o_entry_refused |=> !o_entry_refused)
      else $error("refusal flag stood longer than one cycle");

   chk_done_pulse: assert property (
      o_wake_done |-> state_q[ST_RUN_BIT] ##1 !o_wake_done)
      else $error("wake-done flag wrong");

   chk_state_onehot: assert property (
      $onehot(state_q) && !(o_deep_sleep && o_warmup_active))
      else $error("sequencer state not one-hot");

   chk_warm_ignores_req: assert property (
      o_warmup_active && i_sleep_req |=> !o_deep_sleep)
      else $error("sleep request taken during warm-up");

   chk_sleep_needs_req: assert property (
      !o_deep_sleep && !i_sleep_req |=> !o_deep_sleep)
      else $error("sleep entered without a request");

   chk_exit_rise_wake: assert property (
      o_deep_sleep && !i_level_release_mode && i_exit_pin && !$past(i_exit_pin)
      |=> o_warmup_active)
      else $error("exit pin rise did not release in edge mode");

   chk_sleep_holds: assert property (
      o_deep_sleep && !i_exit_pin && !key_release(i_key_wake_enable, i_key_wake_pin)
      |=> o_deep_sleep)
      else $error("sleep left with no release source");

   chk_refused_key: assert property (
      (state_q == ST_RUN) && i_sleep_req && !i_exit_pin && key_release(i_key_wake_enable, i_key_wake_pin)
      |=> o_entry_refused)
      else $error("enabled key-wake low did not refuse entry");

   cov_refused: cover property (o_entry_refused);
   cov_key_wake: cover property (o_deep_sleep && i_key_wake_enable && !i_key_wake_pin ##1 o_warmup_active);
   cov_edge_wake: cover property (o_deep_sleep && !i_level_release_mode ##1 o_warmup_active);
   cov_full_cycle: cover property (o_wake_done);
   cov_back_to_back: cover property (o_wake_done ##1 o_deep_sleep);

endmodule
`default_nettype wire

// *** deep_sleep_wake_bench.sv ***
// Bench: table of sleep entries, then wake, back-to-back and reset cases.
// Assumes 40 MHz clock; warm-up lasts WARMUP_CYCLES.
`timescale 1ns/1ps
`default_nettype none
module deep_sleep_wake_bench;
   import wake_pkg::*;
   logic clk = 1'b0, rstn = 1'b0, req = 1'b0, exit_cmd = 1'b0, press = 1'b0, en = 1'b0, mode = 1'b1;
   logic exit_pin, key_pin, sleep_o, warm_o, refused_o, done_o;
   int failures = 0, check_count = 0;
   // Row: exit, key press, enable, level mode, expected refusal
   logic [4:0] rows [7] = '{5'h06, 5'h17, 5'h0F, 5'h0A, 5'h11, 5'h04, 5'h08};
   always #12.5 clk = ~clk;
   wake_source src_u (.i_exit_cmd(exit_cmd), .i_key_press(press), .i_key_wake_enable(en),
      .i_level_release_mode(mode), .o_exit_pin(exit_pin), .o_key_wake_pin(key_pin));
   deep_sleep_wake dut_u (.i_sys_clk(clk), .i_rstn(rstn), .i_sleep_req(req), .i_exit_pin(exit_pin),
      .i_key_wake_pin(key_pin), .i_key_wake_enable(en), .i_level_release_mode(mode),
      .o_deep_sleep(sleep_o), .o_warmup_active(warm_o), .o_entry_refused(refused_o), .o_wake_done(done_o));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic step(input int n = 1);
      repeat (n) @(posedge clk);
      #2;
   endtask
   task automatic sleep_now();
      req = 1'b1;
      step();
      req = 1'b0;
   endtask
   // Waits out warm-up from its first cycle
   task automatic finish_warm();
      int n;
      n = 0;
      while (warm_o === 1'b1 && n < 60) begin
         n++;
         if (n == 5) req = 1'b1;
         if (n == 6) req = 1'b0;
         step();
      end
      check(8'(n), 8'(WARMUP_CYCLES));
      check({warm_o, done_o, sleep_o}, 8'h02);
   endtask
   task automatic final_report();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #200000;
      failures++;
      final_report();
   end
   initial begin
      step(4);
      rstn = 1'b1;
      check({sleep_o, warm_o, refused_o, done_o}, 8'h00);
      foreach (rows[i]) begin
         {exit_cmd, press, en, mode} = rows[i][4:1];
         step(2);
         sleep_now();
         check({sleep_o, warm_o, refused_o}, rows[i][0] ? 8'h03 : 8'h04);
         if (!rows[i][0]) begin
            press = 1'b0;
            exit_cmd = 1'b1;
            step();
            check({sleep_o, warm_o}, 8'h01);
         end
         finish_warm();
         $display("row %0d done", i);
      end
      // Key pin read high before sleep, then a level-mode key press
      exit_cmd = 1'b0;
      press = 1'b0;
      {en, mode} = 2'b11;
      step();
      check(key_pin, 1'b1);
      sleep_now();
      step(5);
      check(sleep_o, 1'b1);
      press = 1'b1;
      step();
      check({sleep_o, warm_o}, 8'h01);
      press = 1'b0;
      finish_warm();
      req = 1'b1;
      step();
      req = 1'b0;
      check(sleep_o, 1'b1);
      $display("key wake and back-to-back done");
      // Disabled key pin low never wakes
      en = 1'b0;
      press = 1'b1;
      step(6);
      check({sleep_o, warm_o}, 8'h02);
      press = 1'b0;
      rstn = 1'b0;
      #5;
      check({sleep_o, warm_o, refused_o, done_o}, 8'h00);
      step();
      rstn = 1'b1;
      step();
      sleep_now();
      check(sleep_o, 1'b1);
      $display("disabled key and reset done");
      final_report();
   end
endmodule
`default_nettype wire

// *** wake_detect.sv ***
// Release-condition detector for the exit pin and the key-wake pin.
// Assumes pin levels are synchronous to the system clock.
`timescale 1ns/1ps
`default_nettype none
module wake_detect
   import wake_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   wake_if.detector wif
);

   logic exit_prev_q;
   logic key_active;
   logic exit_rise;

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         exit_prev_q <= EXIT_PREV_RST;
      end else begin
         exit_prev_q <= wif.exit_pin;
      end
   end

   // Enable bit gates the key pin, low level requests wake
   assign key_active = wif.key_wake_enable & ~wif.key_wake_pin;
   assign exit_rise = wif.exit_pin & ~exit_prev_q;

   // Level test is used at sleep entry in both modes
   assign wif.level_req = wif.exit_pin | key_active;

   // Exit pin: high level or rising edge by mode
   assign wif.release_req = wif.level_mode ? (wif.exit_pin | key_active)
                                           : (exit_rise | key_active);

endmodule
`default_nettype wire

// *** wake_if.sv ***
// Interface: pin levels and release requests between sequencer and detector.
// Assumes both ends share the system clock.
`timescale 1ns/1ps
`default_nettype none
interface wake_if;
   logic exit_pin;
   logic key_wake_pin;
   logic key_wake_enable;
   logic level_mode;
   logic level_req;
   logic release_req;

   modport detector (
      input exit_pin,
      input key_wake_pin,
      input key_wake_enable,
      input level_mode,
      output level_req,
      output release_req
   );

   modport sequencer (
      output exit_pin,
      output key_wake_pin,
      output key_wake_enable,
      output level_mode,
      input level_req,
      input release_req
   );
endinterface
`default_nettype wire

// *** wake_pkg.sv ***
// Package: constants and state codes for the deep-sleep wake-up sequencer.
// Assumes a single 40 MHz system clock.
package wake_pkg;

   // System clock period, ns
   localparam int CLK_PERIOD_NS = 25;
   // Warm-up time after release, ns
   localparam int WARMUP_TIME_NS = 1000;
   // Least time, so round up
   localparam int WARMUP_CYCLES = (WARMUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WARM_CNT_W = 6;
   localparam logic [WARM_CNT_W-1:0] WARM_CNT_LAST = 6'(WARMUP_CYCLES - 1);
   localparam logic [WARM_CNT_W-1:0] WARM_CNT_RST = 6'h00;

   // Reset value of the previous exit-pin sample
   localparam logic EXIT_PREV_RST = 1'b0;

   // Bit positions inside the one-hot state code
   localparam int ST_RUN_BIT = 0;
   localparam int ST_SLEEP_BIT = 1;
   localparam int ST_WARM_BIT = 2;

   typedef enum logic [2:0] {
      ST_RUN = 3'h1,
      ST_SLEEP = 3'h2,
      ST_WARM = 3'h4
   } seq_state_t;

endpackage

// *** wake_source.sv ***
// Partner: external wake sources and firmware pin settings.
// Assumes the bench gives commands in the system clock domain.
`timescale 1ns/1ps
`default_nettype none
module wake_source (
   input wire logic i_exit_cmd,
   input wire logic i_key_press,
   input wire logic i_key_wake_enable,
   input wire logic i_level_release_mode,
   output logic o_exit_pin,
   output logic o_key_wake_pin
);
   // Key press keeps the exit pin low, exit pin stays a live source
   assign o_exit_pin = i_exit_cmd & ~i_key_press;
   // Pin is a plain digital input, never analog
   // Edge mode with key enabled: pin held high all sleep long
   assign o_key_wake_pin = ~i_key_press | (i_key_wake_enable & ~i_level_release_mode);
endmodule
`default_nettype wire
